// File: verilog/bsc_pkg.sv
package bsc_pkg;

  // ********************************
  // Widths and timing
  // ********************************
  localparam int PC_W = 16;
  localparam int IO_ADDR_W = 5;
  localparam logic [4:0] IO_BIT_MAX = 5'h1f;
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_ABS_CALL = 3'h4;
  localparam logic [2:0] CYC_EXIT = 3'h4;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_IO_BIT = 3'h2;
  localparam logic [1:0] PC_STEP_ONE = 2'h1;
  localparam logic [1:0] PC_SKIP_SHORT = 2'h2;
  localparam logic [1:0] PC_SKIP_LONG = 2'h3;

  // ********************************
  // Status register bit positions and reset pc
  // ********************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;

  // ********************************
  // Operations decoded upstream
  // ********************************
  typedef enum logic [4:0] {
    BSC_OP_NONE = 5'h00,
    BSC_OP_RELATIVE_JUMP = 5'h01,
    BSC_OP_POINTER_JUMP = 5'h02,
    BSC_OP_ABSOLUTE_JUMP = 5'h03,
    BSC_OP_RELATIVE_CALL = 5'h04,
    BSC_OP_POINTER_CALL = 5'h05,
    BSC_OP_ABSOLUTE_CALL = 5'h06,
    BSC_OP_SUBROUTINE_EXIT = 5'h07,
    BSC_OP_INTERRUPT_EXIT = 5'h08,
    BSC_OP_COMPARE_EQUAL_SKIP = 5'h09,
    BSC_OP_COMPARE_REGS = 5'h0a,
    BSC_OP_COMPARE_WITH_BORROW = 5'h0b,
    BSC_OP_COMPARE_IMMEDIATE = 5'h0c,
    BSC_OP_SKIP_REG_BIT_LOW = 5'h0d,
    BSC_OP_SKIP_REG_BIT_HIGH = 5'h0e,
    BSC_OP_SKIP_IO_BIT_LOW = 5'h0f,
    BSC_OP_SKIP_IO_BIT_HIGH = 5'h10,
    BSC_OP_BRANCH_FLAG_SET = 5'h11,
    BSC_OP_BRANCH_FLAG_CLEAR = 5'h12,
    BSC_OP_BRANCH_SIGNED_GE = 5'h13,
    BSC_OP_BRANCH_SIGNED_LT = 5'h14,
    BSC_OP_IO_BIT_SET = 5'h15,
    BSC_OP_IO_BIT_CLEAR = 5'h16,
    BSC_OP_SHIFT_LEFT_LOGICAL = 5'h17
  } bsc_op_e;

endpackage

// File: verilog/bsc_flag_alu.sv
`timescale 1ns/1ps
// ********************************
// Compare and shift flag unit
// ********************************
module bsc_flag_alu (
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  input wire logic use_carry_in,
  input wire logic shift_in,
  input wire logic [7:0] status_in,
  output logic [7:0] result_out,
  output logic [7:0] status_out
);

  logic [8:0] diff;
  logic [4:0] half;

  // Difference or shift, flags derived from it
  always_comb begin
    status_out = status_in;
    diff = {1'b0, a_in} - {1'b0, b_in} - {8'h00, use_carry_in & carry_in};
    half = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, use_carry_in & carry_in};
    if (shift_in) begin
      result_out = {a_in[6:0], 1'b0};
      status_out[bsc_pkg::FLAG_C] = a_in[7];
      status_out[bsc_pkg::FLAG_H] = a_in[3];
      status_out[bsc_pkg::FLAG_V] = a_in[7] ^ a_in[6];
      status_out[bsc_pkg::FLAG_Z] = (result_out == 8'h00);
    end else begin
      result_out = diff[7:0];
      status_out[bsc_pkg::FLAG_C] = diff[8];
      status_out[bsc_pkg::FLAG_H] = half[4];
      status_out[bsc_pkg::FLAG_V] = (a_in[7] ^ b_in[7]) & (a_in[7] ^ diff[7]);
      // Carry form keeps zero only if it was already set
      status_out[bsc_pkg::FLAG_Z] = (diff[7:0] == 8'h00) &
        (~use_carry_in | status_in[bsc_pkg::FLAG_Z]);
    end
    status_out[bsc_pkg::FLAG_N] = result_out[7];
    status_out[bsc_pkg::FLAG_S] = status_out[bsc_pkg::FLAG_N] ^ status_out[bsc_pkg::FLAG_V];
  end

endmodule

// File: verilog/bsc_exec.sv
`timescale 1ns/1ps
module bsc_exec #(
  parameter int PC_W = bsc_pkg::PC_W,
  parameter int OFFSET_W = 12
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire bsc_pkg::bsc_op_e op_in,
  input wire logic [OFFSET_W-1:0] offset_in,
  input wire logic [PC_W-1:0] target_in,
  input wire logic [PC_W-1:0] z_pointer_in,
  input wire logic [PC_W-1:0] stack_pc_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] reg_a_in,
  input wire logic [7:0] reg_b_in,
  input wire logic [7:0] io_data_in,
  input wire logic [bsc_pkg::IO_ADDR_W-1:0] io_addr_in,
  input wire logic next_two_word_in,
  output logic busy_out,
  output logic done_out,
  output logic [PC_W-1:0] pc_out,
  output logic [7:0] status_out,
  output logic [PC_W-1:0] push_pc_out,
  output logic push_out,
  output logic pop_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_we_out,
  output logic [bsc_pkg::IO_ADDR_W-1:0] io_addr_out,
  output logic [7:0] io_wmask_out,
  output logic [7:0] io_wdata_out,
  output logic io_we_out
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [2:0] cnt;
    logic busy;
    logic done;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] pc_pending;
    logic [7:0] status;
    logic [PC_W-1:0] push_pc;
    logic push;
    logic pop;
    logic [7:0] reg_wdata;
    logic reg_we;
    logic [bsc_pkg::IO_ADDR_W-1:0] io_addr;
    logic [7:0] io_wmask;
    logic [7:0] io_wdata;
    logic io_we;
    logic irq_restore;
  } bsc_state_s;

  bsc_state_s state_q;
  bsc_state_s state_d;
  logic [7:0] alu_result;
  logic [7:0] alu_status;
  logic alu_shift;
  logic alu_use_carry;
  logic [7:0] alu_b;

  // ********************************
  // Helpers
  // ********************************
  // Offset plus one added to current pc
  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                 input logic [OFFSET_W-1:0] k);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-OFFSET_W){k[OFFSET_W-1]}}, k};
    return pc + ext + {{(PC_W-1){1'b0}}, 1'b1};
  endfunction

  // Skip length by size of next instruction
  function automatic logic [1:0] skip_step(input logic two_word);
    return two_word ? bsc_pkg::PC_SKIP_LONG : bsc_pkg::PC_SKIP_SHORT;
  endfunction

  // Bit select into one-hot mask
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction

  // Pc advanced by a short step
  function automatic logic [PC_W-1:0] pc_plus(input logic [PC_W-1:0] pc,
                                              input logic [1:0] inc);
    return pc + {{(PC_W-2){1'b0}}, inc};
  endfunction

  // Signed less-than test, N xor V
  function automatic logic signed_lt(input logic [7:0] status);
    return status[bsc_pkg::FLAG_N] ^ status[bsc_pkg::FLAG_V];
  endfunction

  // Compare and shift flag unit
  assign alu_shift = (op_in == bsc_pkg::BSC_OP_SHIFT_LEFT_LOGICAL);
  assign alu_use_carry = (op_in == bsc_pkg::BSC_OP_COMPARE_WITH_BORROW);
  assign alu_b = reg_b_in;

  bsc_flag_alu u_alu (
    .a_in(reg_a_in),
    .b_in(alu_b),
    .carry_in(state_q.status[bsc_pkg::FLAG_C]),
    .use_carry_in(alu_use_carry),
    .shift_in(alu_shift),
    .status_in(state_q.status),
    .result_out(alu_result),
    .status_out(alu_status)
  );

  // ********************************
  // Next state
  // ********************************
  // Decode, cycle count and pc update
  always_comb begin
    logic [1:0] step;
    logic [PC_W-1:0] tgt;
    logic [2:0] cycles;
    logic taken;
    logic skip;
    logic flag_bit;
    step = bsc_pkg::PC_STEP_ONE;
    tgt = '0;
    cycles = bsc_pkg::CYC_ONE;
    taken = 1'b0;
    skip = 1'b0;
    flag_bit = state_q.status[bit_sel_in];
    state_d = state_q;
    state_d.done = 1'b0;
    state_d.push = 1'b0;
    state_d.pop = 1'b0;
    state_d.reg_we = 1'b0;
    state_d.io_we = 1'b0;
    if (state_q.busy) begin
      state_d.cnt = state_q.cnt - 3'h1;
      if (state_q.cnt == 3'h1) begin
        state_d.busy = 1'b0;
        state_d.done = 1'b1;
        state_d.pc = state_q.pc_pending;
        if (state_q.irq_restore) begin
          state_d.status[bsc_pkg::FLAG_I] = 1'b1;
        end
        state_d.irq_restore = 1'b0;
      end
    end else if (start_in) begin
      tgt = pc_plus(state_q.pc, step);
      unique case (op_in)
        bsc_pkg::BSC_OP_RELATIVE_JUMP: begin
          tgt = rel_target(state_q.pc, offset_in);
          cycles = bsc_pkg::CYC_REL_JUMP;
        end
        bsc_pkg::BSC_OP_POINTER_JUMP: begin
          tgt = z_pointer_in;
          cycles = bsc_pkg::CYC_REL_JUMP;
        end
        bsc_pkg::BSC_OP_ABSOLUTE_JUMP: begin
          tgt = target_in;
          cycles = bsc_pkg::CYC_ABS_JUMP;
        end
        bsc_pkg::BSC_OP_RELATIVE_CALL, bsc_pkg::BSC_OP_POINTER_CALL: begin
          tgt = (op_in == bsc_pkg::BSC_OP_POINTER_CALL) ? z_pointer_in
                : rel_target(state_q.pc, offset_in);
          cycles = bsc_pkg::CYC_REL_CALL;
          state_d.push = 1'b1;
          state_d.push_pc = pc_plus(state_q.pc, bsc_pkg::PC_STEP_ONE);
        end
        bsc_pkg::BSC_OP_ABSOLUTE_CALL: begin
          tgt = target_in;
          cycles = bsc_pkg::CYC_ABS_CALL;
          state_d.push = 1'b1;
          state_d.push_pc = pc_plus(state_q.pc, 2'h2);
        end
        bsc_pkg::BSC_OP_SUBROUTINE_EXIT, bsc_pkg::BSC_OP_INTERRUPT_EXIT: begin
          tgt = stack_pc_in;
          cycles = bsc_pkg::CYC_EXIT;
          state_d.pop = 1'b1;
          state_d.irq_restore = (op_in == bsc_pkg::BSC_OP_INTERRUPT_EXIT);
        end
        bsc_pkg::BSC_OP_COMPARE_EQUAL_SKIP: begin
          skip = (reg_a_in == reg_b_in);
        end
        bsc_pkg::BSC_OP_COMPARE_REGS, bsc_pkg::BSC_OP_COMPARE_WITH_BORROW,
        bsc_pkg::BSC_OP_COMPARE_IMMEDIATE: begin
          state_d.status = alu_status;
        end
        bsc_pkg::BSC_OP_SKIP_REG_BIT_LOW: begin
          skip = ~reg_a_in[bit_sel_in];
        end
        bsc_pkg::BSC_OP_SKIP_REG_BIT_HIGH: begin
          skip = reg_a_in[bit_sel_in];
        end
        bsc_pkg::BSC_OP_SKIP_IO_BIT_LOW: begin
          skip = ~io_data_in[bit_sel_in];
        end
        bsc_pkg::BSC_OP_SKIP_IO_BIT_HIGH: begin
          skip = io_data_in[bit_sel_in];
        end
        // Named flag branches map onto these through bit_sel_in
        bsc_pkg::BSC_OP_BRANCH_FLAG_SET: begin
          taken = flag_bit;
        end
        bsc_pkg::BSC_OP_BRANCH_FLAG_CLEAR: begin
          taken = ~flag_bit;
        end
        bsc_pkg::BSC_OP_BRANCH_SIGNED_GE: begin
          taken = ~signed_lt(state_q.status);
        end
        bsc_pkg::BSC_OP_BRANCH_SIGNED_LT: begin
          taken = signed_lt(state_q.status);
        end
        bsc_pkg::BSC_OP_IO_BIT_SET, bsc_pkg::BSC_OP_IO_BIT_CLEAR: begin
          cycles = bsc_pkg::CYC_IO_BIT;
          state_d.io_we = 1'b1;
          state_d.io_addr = io_addr_in;
          state_d.io_wmask = bit_mask(bit_sel_in);
          state_d.io_wdata = (op_in == bsc_pkg::BSC_OP_IO_BIT_SET)
                             ? bit_mask(bit_sel_in) : 8'h00;
        end
        bsc_pkg::BSC_OP_SHIFT_LEFT_LOGICAL: begin
          state_d.status = alu_status;
          state_d.reg_wdata = alu_result;
          state_d.reg_we = 1'b1;
        end
        default: begin
          cycles = bsc_pkg::CYC_ONE;
        end
      endcase
      if (taken) begin
        tgt = rel_target(state_q.pc, offset_in);
        cycles = bsc_pkg::CYC_REL_JUMP;
      end
      if (skip) begin
        step = skip_step(next_two_word_in);
        tgt = pc_plus(state_q.pc, step);
        cycles = {1'b0, step};
      end
      if (cycles == bsc_pkg::CYC_ONE) begin
        state_d.pc = tgt;
        state_d.done = 1'b1;
      end else begin
        state_d.pc_pending = tgt;
        state_d.busy = 1'b1;
        state_d.cnt = cycles - 3'h1;
      end
    end
  end

  // ********************************
  // Registers
  // ********************************
  // State register, cleared by reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_q <= '0;
      state_q.pc <= bsc_pkg::PC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops
  assign busy_out = state_q.busy;
  assign done_out = state_q.done;
  assign pc_out = state_q.pc;
  assign status_out = state_q.status;
  assign push_pc_out = state_q.push_pc;
  assign push_out = state_q.push;
  assign pop_out = state_q.pop;
  assign reg_wdata_out = state_q.reg_wdata;
  assign reg_we_out = state_q.reg_we;
  assign io_addr_out = state_q.io_addr;
  assign io_wmask_out = state_q.io_wmask;
  assign io_wdata_out = state_q.io_wdata;
  assign io_we_out = state_q.io_we;

endmodule

// File: testbench/bsc_exec_asserts.sv
`timescale 1ns/1ps
// ********************************
// Execution unit checker
// ********************************
module bsc_exec_asserts #(
  parameter int PC_W = 16,
  parameter int OFFSET_W = 12
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire bsc_pkg::bsc_op_e op_in,
  input wire logic [OFFSET_W-1:0] offset_in,
  input wire logic [PC_W-1:0] target_in,
  input wire logic [PC_W-1:0] stack_pc_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] reg_a_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [7:0] status_out,
  input wire logic push_out,
  input wire logic pop_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic reg_we_out,
  input wire logic [7:0] io_wmask_out,
  input wire logic [7:0] io_wdata_out,
  input wire logic io_we_out
);
  logic take;
  // Accepted request
  assign take = start_in && !busy_out;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  rel_jump_a: assert property (
    take && op_in == bsc_pkg::BSC_OP_RELATIVE_JUMP |-> ##1 busy_out ##1 done_out &&
    pc_out == PC_W'($past(pc_out, 2) + 1 +
    {{(PC_W-OFFSET_W){$past(offset_in[OFFSET_W-1], 2)}}, $past(offset_in, 2)}))
    else $error("relative jump target or timing wrong");
  abs_jump_a: assert property (
    take && op_in == bsc_pkg::BSC_OP_ABSOLUTE_JUMP |=> !done_out [*2] ##1 done_out &&
    pc_out == $past(target_in, 3) && status_out == $past(status_out, 3))
    else $error("absolute jump wrong");
  call_push_a: assert property (
    take && op_in inside {bsc_pkg::BSC_OP_RELATIVE_CALL, bsc_pkg::BSC_OP_POINTER_CALL}
    |=> push_out ##2 done_out)
    else $error("call push or timing wrong");
  exit_pc_a: assert property (
    take && op_in inside {bsc_pkg::BSC_OP_SUBROUTINE_EXIT, bsc_pkg::BSC_OP_INTERRUPT_EXIT}
    |=> pop_out ##3 done_out && pc_out == $past(stack_pc_in, 4))
    else $error("exit wrong");
  compare_nowrite_a: assert property (
    take && op_in inside {bsc_pkg::BSC_OP_COMPARE_REGS, bsc_pkg::BSC_OP_COMPARE_WITH_BORROW,
    bsc_pkg::BSC_OP_COMPARE_IMMEDIATE} |=> done_out && !reg_we_out)
    else $error("compare wrote back or was late");
  io_set_a: assert property (
    take && op_in == bsc_pkg::BSC_OP_IO_BIT_SET |=> io_we_out &&
    io_wmask_out == (8'h01 << $past(bit_sel_in)) && (io_wdata_out & io_wmask_out) != 8'h00
    ##1 done_out)
    else $error("bit set wrong");
  io_clear_a: assert property (
    take && op_in == bsc_pkg::BSC_OP_IO_BIT_CLEAR |=> io_we_out &&
    io_wmask_out == (8'h01 << $past(bit_sel_in)) && (io_wdata_out & io_wmask_out) == 8'h00
    ##1 done_out)
    else $error("bit clear wrong");
  shift_left_a: assert property (
    take && op_in == bsc_pkg::BSC_OP_SHIFT_LEFT_LOGICAL |=> reg_we_out && done_out &&
    reg_wdata_out == {$past(reg_a_in[6:0]), 1'b0} && status_out[0] == $past(reg_a_in[7]))
    else $error("shift wrong");
endmodule

bind bsc_exec bsc_exec_asserts #(.PC_W(PC_W), .OFFSET_W(OFFSET_W)) chk (
  .clock_in(clock_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
  .offset_in(offset_in), .target_in(target_in), .stack_pc_in(stack_pc_in),
  .bit_sel_in(bit_sel_in), .reg_a_in(reg_a_in), .busy_out(busy_out), .done_out(done_out),
  .pc_out(pc_out), .status_out(status_out), .push_out(push_out), .pop_out(pop_out),
  .reg_wdata_out(reg_wdata_out), .reg_we_out(reg_we_out), .io_wmask_out(io_wmask_out),
  .io_wdata_out(io_wdata_out), .io_we_out(io_we_out)
);

// File: testbench/bsc_env_model.sv
`timescale 1ns/1ps
// ********************************
// I/O space and one-deep stack
// ********************************
module bsc_env_model (
  input wire logic clock_in,
  input wire logic [4:0] io_addr_in,
  input wire logic [4:0] io_waddr_in,
  input wire logic [7:0] io_wmask_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic io_we_in,
  input wire logic [15:0] push_pc_in,
  input wire logic push_in,
  output logic [7:0] io_data_out,
  output logic [15:0] stack_pc_out
);
  logic [7:0] io_mem [32];
  // Seeded register contents
  initial begin
    for (int i = 0; i < 32; i++) io_mem[i] = 8'(i) ^ 8'ha5;
    stack_pc_out = 16'h0000;
  end
  assign io_data_out = io_mem[io_addr_in];
  // Masked write, return address latch
  always @(posedge clock_in) begin
    if (io_we_in) io_mem[io_waddr_in] <= (io_mem[io_waddr_in] & ~io_wmask_in) |
      (io_wdata_in & io_wmask_in);
    if (push_in) stack_pc_out <= push_pc_in;
  end
endmodule

// File: testbench/bsc_exec_tb_top.sv
`timescale 1ns/1ps
module bsc_exec_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic start_in = 1'b0;
  bsc_pkg::bsc_op_e op_in = bsc_pkg::BSC_OP_NONE;
  logic [11:0] offset_in = 12'h000;
  logic [15:0] target_in = 16'h1234;
  logic [15:0] z_pointer_in = 16'h0100;
  logic [2:0] bit_sel_in = 3'h0;
  logic [7:0] reg_a_in = 8'h00;
  logic [7:0] reg_b_in = 8'h00;
  logic [4:0] io_addr_in = 5'h1f;
  logic next_two_word_in = 1'b0;
  logic [15:0] stack_pc, pc_out, push_pc_out;
  logic [7:0] io_data, status_out, reg_wdata_out, io_wmask_out, io_wdata_out;
  logic [4:0] io_addr_out;
  logic busy_out, done_out, push_out, pop_out, reg_we_out, io_we_out;
  logic [11:0] k_v = 12'h000;
  logic two_v = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [15:0] ret;
  logic [7:0] st = 8'h00;
  int errors = 0;
  int n_compared = 0;
  bsc_exec dut (
    .clock_in(clock_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
    .offset_in(offset_in), .target_in(target_in), .z_pointer_in(z_pointer_in),
    .stack_pc_in(stack_pc), .bit_sel_in(bit_sel_in), .reg_a_in(reg_a_in),
    .reg_b_in(reg_b_in), .io_data_in(io_data), .io_addr_in(io_addr_in),
    .next_two_word_in(next_two_word_in), .busy_out(busy_out), .done_out(done_out),
    .pc_out(pc_out), .status_out(status_out), .push_pc_out(push_pc_out),
    .push_out(push_out), .pop_out(pop_out), .reg_wdata_out(reg_wdata_out),
    .reg_we_out(reg_we_out), .io_addr_out(io_addr_out), .io_wmask_out(io_wmask_out),
    .io_wdata_out(io_wdata_out), .io_we_out(io_we_out)
  );
  bsc_env_model env (
    .clock_in(clock_in), .io_addr_in(io_addr_in), .io_waddr_in(io_addr_out),
    .io_wmask_in(io_wmask_out), .io_wdata_in(io_wdata_out), .io_we_in(io_we_out),
    .push_pc_in(push_pc_out), .push_in(push_out), .io_data_out(io_data),
    .stack_pc_out(stack_pc)
  );
  // Clock
  initial begin
    forever #50 clock_in = ~clock_in;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One operation: issue, wait for done, judge cycles, pc step and flags
  task automatic run(input bsc_pkg::bsc_op_e op, input logic [7:0] a, b,
                     input logic [2:0] sel, input int cyc, input logic [15:0] d);
    int cnt;
    @(posedge clock_in);
    op_in <= op;
    reg_a_in <= a;
    reg_b_in <= b;
    bit_sel_in <= sel;
    offset_in <= k_v;
    next_two_word_in <= two_v;
    start_in <= 1'b1;
    @(posedge clock_in);
    start_in <= 1'b0;
    cnt = 0;
    do begin
      @(negedge clock_in);
      cnt++;
    end while (done_out !== 1'b1 && cnt < 8);
    if (done_out !== 1'b1) begin
      errors++;
      $display("BAD t=%0t done %h exp %h", $time, done_out, 1'b1);
      wrap_up();
    end
    pc = pc + d;
    chk(16'(cnt), 16'(cyc));
    chk(pc_out, pc);
    chk({8'h00, status_out}, {8'h00, st});
  endtask
  // Compare, then every flag branch both ways
  task automatic cmp_br(input bsc_pkg::bsc_op_e op, input logic [7:0] a, b, e);
    logic t;
    st = e;
    run(op, a, b, 3'h0, 1, 16'h0001);
    k_v = 12'h004;
    for (int s = 0; s < 8; s++) begin
      t = st[s];
      run(bsc_pkg::BSC_OP_BRANCH_FLAG_SET, a, b, 3'(s), t ? 2 : 1, t ? 16'h0005 : 16'h0001);
      run(bsc_pkg::BSC_OP_BRANCH_FLAG_CLEAR, a, b, 3'(s), t ? 1 : 2, t ? 16'h0001 : 16'h0005);
    end
    t = st[2] ^ st[3];
    run(bsc_pkg::BSC_OP_BRANCH_SIGNED_GE, a, b, 3'h0, t ? 1 : 2, t ? 16'h0001 : 16'h0005);
    run(bsc_pkg::BSC_OP_BRANCH_SIGNED_LT, a, b, 3'h0, t ? 2 : 1, t ? 16'h0005 : 16'h0001);
  endtask
  // Skip with one-word and two-word follower
  task automatic skip2(input bsc_pkg::bsc_op_e op, input logic [7:0] a, b,
                       input logic [2:0] sel, input logic hit);
    for (int w = 0; w < 2; w++) begin
      two_v = w[0];
      run(op, a, b, sel, hit ? 2 + w : 1, hit ? 16'(2 + w) : 16'h0001);
    end
  endtask
  // Mid-run reset clears pc, status, busy and done, then a jump runs again
  task automatic reset_mid();
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    @(negedge clock_in);
    chk(pc_out, 16'h0000);
    chk({8'h00, status_out}, 16'h0000);
    chk({14'h0000, busy_out, done_out}, 16'h0000);
    pc = 16'h0000;
    st = 8'h00;
    k_v = 12'h004;
    run(bsc_pkg::BSC_OP_RELATIVE_JUMP, 8'h00, 8'h00, 3'h0, 2, 16'h0005);
    $display("reset finished");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    k_v = 12'hffd;
    run(bsc_pkg::BSC_OP_RELATIVE_JUMP, 8'h00, 8'h00, 3'h0, 2, 16'hfffe);
    k_v = 12'h7ff;
    run(bsc_pkg::BSC_OP_RELATIVE_JUMP, 8'h00, 8'h00, 3'h0, 2, 16'h0800);
    run(bsc_pkg::BSC_OP_POINTER_JUMP, 8'h00, 8'h00, 3'h0, 2, 16'h0100 - pc);
    run(bsc_pkg::BSC_OP_ABSOLUTE_JUMP, 8'h00, 8'h00, 3'h0, 3, 16'h1234 - pc);
    $display("jumps finished");
    k_v = 12'h010;
    ret = pc + 16'h0001;
    run(bsc_pkg::BSC_OP_RELATIVE_CALL, 8'h00, 8'h00, 3'h0, 3, 16'h0011);
    run(bsc_pkg::BSC_OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 3'h0, 4, ret - pc);
    ret = pc + 16'h0001;
    run(bsc_pkg::BSC_OP_POINTER_CALL, 8'h00, 8'h00, 3'h0, 3, 16'h0100 - pc);
    st = 8'h80;
    run(bsc_pkg::BSC_OP_INTERRUPT_EXIT, 8'h00, 8'h00, 3'h0, 4, ret - pc);
    ret = pc + 16'h0002;
    run(bsc_pkg::BSC_OP_ABSOLUTE_CALL, 8'h00, 8'h00, 3'h0, 4, 16'h1234 - pc);
    run(bsc_pkg::BSC_OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 3'h0, 4, ret - pc);
    $display("calls finished");
    cmp_br(bsc_pkg::BSC_OP_COMPARE_REGS, 8'h00, 8'h01, 8'hb5);
    cmp_br(bsc_pkg::BSC_OP_COMPARE_WITH_BORROW, 8'h05, 8'h04, 8'h80);
    cmp_br(bsc_pkg::BSC_OP_COMPARE_REGS, 8'h05, 8'h05, 8'h82);
    cmp_br(bsc_pkg::BSC_OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'hb8);
    $display("compares and branches finished");
    skip2(bsc_pkg::BSC_OP_COMPARE_EQUAL_SKIP, 8'h05, 8'h05, 3'h0, 1'b1);
    skip2(bsc_pkg::BSC_OP_COMPARE_EQUAL_SKIP, 8'h05, 8'h06, 3'h0, 1'b0);
    skip2(bsc_pkg::BSC_OP_SKIP_REG_BIT_LOW, 8'hfe, 8'h00, 3'h0, 1'b1);
    skip2(bsc_pkg::BSC_OP_SKIP_REG_BIT_LOW, 8'hfe, 8'h00, 3'h1, 1'b0);
    skip2(bsc_pkg::BSC_OP_SKIP_REG_BIT_HIGH, 8'h80, 8'h00, 3'h7, 1'b1);
    skip2(bsc_pkg::BSC_OP_SKIP_IO_BIT_LOW, 8'h00, 8'h00, 3'h0, 1'b1);
    skip2(bsc_pkg::BSC_OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h00, 3'h0, 1'b0);
    skip2(bsc_pkg::BSC_OP_SKIP_IO_BIT_HIGH, 8'h00, 8'h00, 3'h1, 1'b1);
    $display("skips finished");
    run(bsc_pkg::BSC_OP_IO_BIT_CLEAR, 8'h00, 8'h00, 3'h1, 2, 16'h0001);
    run(bsc_pkg::BSC_OP_IO_BIT_SET, 8'h00, 8'h00, 3'h0, 2, 16'h0001);
    chk({8'h00, env.io_mem[31]}, 16'h00b9);
    st = 8'h99;
    run(bsc_pkg::BSC_OP_SHIFT_LEFT_LOGICAL, 8'h81, 8'h00, 3'h0, 1, 16'h0001);
    $display("bit and shift finished");
    reset_mid();
    wrap_up();
  end
endmodule
